// ---- design/ers_sequencer.sv ----
`timescale 1ns/1ps
module ers_sequencer
  import ers_pkg::*;
#(
  parameter int PC_W = PC_W_DEF,
  parameter int CNT_W = CNT_W_DEF,
  parameter int INIT_CYC = INIT_CYC_DEF,
  parameter int WARM_CYC = WARM_CYC_DEF,
  parameter int WDT_W = WDT_W_DEF,
  parameter int DIV_W = DIV_W_DEF,
  parameter int WDT_DIV = WDT_DIV_DEF
) (
  input wire logic core_clk, // System clock, 40 MHz
  input wire logic rst, // Synchronous reset, active high
  input wire logic rst_pin_n, // External reset pin, active low
  input wire logic rst_pin_en, // Option: pin acts as reset
  input wire logic supply_ok, // Supply in normal range
  input wire logic osc_ready, // Oscillator running and stable
  input wire logic wdt_en, // Watchdog enable
  input wire logic wdt_clear, // Software watchdog clear pulse
  output logic sys_rst, // System reset, active high
  output logic reg_init, // Register default load strobe
  output logic fetch_start, // One-cycle start-of-execution pulse
  output logic [PC_W-1:0] pc_start, // Start fetch address
  output logic wdt_cause, // Set by a watchdog reset, cleared by a pin reset; kept through supply loss
  output logic [4:0] seq_phase // Current phase, one-hot
);

  // ==========================================================
  // Constants at working widths
  localparam logic [CNT_W-1:0] INIT_LAST = CNT_W'(INIT_CYC - 1);
  localparam logic [CNT_W-1:0] WARM_LAST = CNT_W'(WARM_CYC - 1);
  localparam logic [DIV_W-1:0] DIV_LAST = DIV_W'(WDT_DIV - 1);
  localparam logic [WDT_W-1:0] WDT_MAX = '1;
  localparam logic [PC_W-1:0] START_ADDR = '0;
  localparam logic [CNT_W-1:0] CNT_ONE = CNT_W'(1);
  localparam logic [DIV_W-1:0] DIV_ONE = DIV_W'(1);
  localparam logic [WDT_W-1:0] WDT_ONE = WDT_W'(1);

  // ==========================================================
  // Input synchronisation
  ers_sync_if #(.W(SYNC_W)) sync_if ();

  assign sync_if.raw[SB_PIN] = rst_pin_n;
  assign sync_if.raw[SB_PIN_EN] = rst_pin_en;
  assign sync_if.raw[SB_SUPPLY] = supply_ok;
  assign sync_if.raw[SB_OSC] = osc_ready;

  ers_sync #(.W(SYNC_W)) u_sync (
    .core_clk (core_clk),
    .rst (rst),
    .port (sync_if.sync_side)
  );

  logic pin_n_s;
  logic pin_en_s;
  logic supply_s;
  logic osc_s;
  logic pin_active;

  // Only synchronised copies reach the sequencer
  assign pin_n_s = sync_if.sync[SB_PIN];
  assign pin_en_s = sync_if.sync[SB_PIN_EN];
  assign supply_s = sync_if.sync[SB_SUPPLY];
  assign osc_s = sync_if.sync[SB_OSC];
  // Low level on an enabled pin means reset
  assign pin_active = pin_en_s && !pin_n_s;

  // ==========================================================
  // Watchdog
  ers_state_t state;
  logic [DIV_W-1:0] div_cnt;
  logic [DIV_W-1:0] next_div_cnt;
  logic [WDT_W-1:0] wdt_cnt;
  logic [WDT_W-1:0] next_wdt_cnt;
  logic wdt_tick;
  logic wdt_ovf;

  // Divider tick, then counter; counter held clear outside execution, divider free-running
  always_comb begin
    wdt_tick = (div_cnt == DIV_LAST);
    wdt_ovf = (state == ST_RUN) && wdt_en && wdt_tick &&
              !wdt_clear && (wdt_cnt == WDT_MAX);
    next_div_cnt = wdt_tick ? '0 : div_cnt + DIV_ONE;
    next_wdt_cnt = wdt_cnt;
    if (state != ST_RUN || !wdt_en || wdt_clear) begin
      next_wdt_cnt = '0;
    end else if (wdt_tick) begin
      next_wdt_cnt = wdt_cnt + WDT_ONE;
    end
  end

  always_ff @(posedge core_clk) begin
    if (rst) begin
      div_cnt <= '0;
      wdt_cnt <= '0;
    end else begin
      div_cnt <= next_div_cnt;
      wdt_cnt <= next_wdt_cnt;
    end
  end

  // ==========================================================
  // Sequencer
  ers_state_t next_state;
  logic [CNT_W-1:0] init_cnt;
  logic [CNT_W-1:0] next_init_cnt;
  logic [CNT_W-1:0] warm_cnt;
  logic [CNT_W-1:0] next_warm_cnt;
  logic next_sys_rst;
  logic next_reg_init;
  logic next_fetch_start;
  logic next_wdt_cause;

  // Phase steps; reset causes override at the end by priority
  always_comb begin
    next_state = state;
    next_init_cnt = init_cnt;
    next_warm_cnt = warm_cnt;
    next_wdt_cause = wdt_cause;
    case (state)
      ST_POWER: begin
        if (supply_s) begin
          next_state = ST_HOLD;
        end
      end
      ST_HOLD: begin
        if (!pin_active) begin
          next_state = ST_INIT;
          next_init_cnt = '0;
        end
      end
      ST_INIT: begin
        if (init_cnt == INIT_LAST) begin
          next_state = ST_WARM;
          next_warm_cnt = '0;
        end else begin
          next_init_cnt = init_cnt + CNT_ONE;
        end
      end
      ST_WARM: begin
        // A clock that drops out restarts the warm-up count
        if (!osc_s) begin
          next_warm_cnt = '0;
        end else if (warm_cnt == WARM_LAST) begin
          next_state = ST_RUN;
        end else begin
          next_warm_cnt = warm_cnt + CNT_ONE;
        end
      end
      ST_RUN: begin
        next_state = ST_RUN;
      end
      default: begin
        next_state = ST_POWER;
      end
    endcase
    if (wdt_ovf) begin
      next_state = ST_POWER;
      next_wdt_cause = 1'b1;
    end
    if (pin_active) begin
      next_state = ST_HOLD;
      next_wdt_cause = 1'b0;
    end
    // Supply loss wins: a watchdog restart cannot finish in dead-band
    if (!supply_s) begin
      next_state = ST_POWER;
    end
    next_sys_rst = (next_state != ST_RUN);
    next_reg_init = (next_state == ST_INIT);
    next_fetch_start = (next_state == ST_RUN) && (state != ST_RUN);
  end

  always_ff @(posedge core_clk) begin
    if (rst) begin
      state <= ST_POWER;
      init_cnt <= '0;
      warm_cnt <= '0;
      sys_rst <= RST_ASSERTED;
      reg_init <= 1'b0;
      fetch_start <= 1'b0;
      wdt_cause <= 1'b0;
      pc_start <= START_ADDR;
    end else begin
      state <= next_state;
      init_cnt <= next_init_cnt;
      warm_cnt <= next_warm_cnt;
      sys_rst <= next_sys_rst;
      reg_init <= next_reg_init;
      fetch_start <= next_fetch_start;
      wdt_cause <= next_wdt_cause;
      pc_start <= START_ADDR;
    end
  end

  assign seq_phase = state;

  // ==========================================================
  // Checks
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (rst);

  a_pin_forces_reset: assert property (
    // Supply loss outranks the pin, so only a good supply implies HOLD
    pin_active && supply_s |=> sys_rst && state == ST_HOLD)
    else $error("active reset pin did not force reset");

  a_pin_disabled: assert property (
    state == ST_RUN && !pin_en_s && supply_s && !wdt_ovf |=> !sys_rst)
    else $error("disabled reset pin caused a reset");

  a_hold_release: assert property (
    state == ST_HOLD && pin_active && supply_s |=>
    state == ST_HOLD ##0 sys_rst)
    else $error("left hold while pin still low");

  a_init_first: assert property (
    $rose(state == ST_WARM) |-> $past(state == ST_INIT) &&
    $past(init_cnt == INIT_LAST) && $past(reg_init))
    else $error("warm-up entered without full init");

  a_warm_osc: assert property (
    $rose(state == ST_RUN) |-> $past(osc_s) &&
    $past(warm_cnt == WARM_LAST) && $past(state == ST_WARM))
    else $error("execution began before warm-up ended");

  a_fetch_zero: assert property (
    fetch_start |-> !sys_rst && pc_start == START_ADDR &&
    $past(sys_rst))
    else $error("start pulse wrong or not from address zero");

  a_wdt_resets: assert property (
    wdt_ovf && supply_s && !pin_active |=>
    state == ST_POWER && sys_rst && wdt_cause)
    else $error("watchdog overflow did not reset");

  a_wdt_counts: assert property (
    state == ST_RUN && wdt_en && wdt_tick && !wdt_clear && !wdt_ovf
    |=> wdt_cnt == $past(wdt_cnt) + WDT_ONE)
    else $error("watchdog did not advance");

  a_supply_hold: assert property (
    !supply_s |=> state == ST_POWER && sys_rst)
    else $error("sequence advanced on bad supply");

  c_reach_run: cover property ($rose(state == ST_RUN));
  c_wdt_reset: cover property (wdt_ovf ##1 state == ST_POWER);
  c_pin_in_run: cover property (state == ST_RUN && pin_active);
  c_pin_ignored: cover property (state == ST_RUN && !pin_en_s &&
                                 !pin_n_s);

endmodule

// ---- design/ers_sync.sv ----
`timescale 1ns/1ps
// ==========================================================
// Two-flop synchroniser bank
module ers_sync
  import ers_pkg::*;
#(
  parameter int W = SYNC_W
) (
  input wire logic core_clk, // System clock
  input wire logic rst, // Synchronous reset, active high
  ers_sync_if.sync_side port // Raw in, synchronised out
);

  logic [W-1:0] stage1;
  logic [W-1:0] stage2;
  logic [W-1:0] next_stage1;
  logic [W-1:0] next_stage2;

  // First stage is read only by the second
  always_comb begin
    next_stage1 = port.raw;
    next_stage2 = stage1;
  end

  // Reset to constants; pins are caught after release
  always_ff @(posedge core_clk) begin
    if (rst) begin
      stage1 <= SYNC_RST;
      stage2 <= SYNC_RST;
    end else begin
      stage1 <= next_stage1;
      stage2 <= next_stage2;
    end
  end

  assign port.sync = stage2;

  // ==========================================================
  // Checks
  a_sync_delay: assert property (
    @(posedge core_clk) disable iff (rst)
    !$past(rst) && !$past(rst, 2) |-> port.sync == $past(port.raw, 2))
    else $error("synchroniser latency is not two cycles");

endmodule

// ---- dv/ers_rst_ic.sv ----
`timescale 1ns/1ps
// ==========================================================
// Reset supervisor on the far side of the reset pin
module ers_rst_ic #(
  parameter int STRETCH = 4
) (
  input wire logic core_clk, // System clock
  input wire logic hold, // Bench asks for reset to be held
  output logic rst_pin_n // Reset pin, pulled high when released
);
  // Starts asserted, as a supervisor does at power-up
  int cnt = STRETCH;
  // Release is stretched, so the pin never bounces on a short request
  always @(posedge core_clk) begin
    if (hold) begin
      cnt <= STRETCH;
    end else if (cnt != 0) begin
      cnt <= cnt - 1;
    end
  end
  // Low level means reset; high only after the stretch runs out
  assign rst_pin_n = (cnt == 0);
endmodule

// ---- dv/testbench.sv ----
`timescale 1ns/1ps
// ==========================================================
// Bench for the reset sequencer
module testbench;
  import ers_pkg::*;
  localparam int INIT_N = 4;
  localparam int WARM_N = 8;
  logic core_clk = 1'b0;
  logic rst = 1'b1;
  logic hold = 1'b1;
  logic rst_pin_en = 1'b1;
  logic supply_ok = 1'b1;
  logic osc_ready = 1'b1;
  logic wdt_en = 1'b0;
  logic wdt_clear = 1'b0;
  logic rst_pin_n, sys_rst, reg_init, fetch_start, wdt_cause;
  logic [11:0] pc_start;
  logic [4:0] seq_phase;
  int error_cnt = 0;
  int comparisons = 0;
  int cycles = 0;
  int n;

  // Short warm-up and watchdog keep the run brief
  ers_sequencer #(.INIT_CYC(INIT_N), .WARM_CYC(WARM_N), .WDT_W(3),
    .DIV_W(2), .WDT_DIV(4)) i_dut (.core_clk(core_clk), .rst(rst),
    .rst_pin_n(rst_pin_n), .rst_pin_en(rst_pin_en),
    .supply_ok(supply_ok), .osc_ready(osc_ready), .wdt_en(wdt_en),
    .wdt_clear(wdt_clear), .sys_rst(sys_rst), .reg_init(reg_init),
    .fetch_start(fetch_start), .pc_start(pc_start),
    .wdt_cause(wdt_cause), .seq_phase(seq_phase));
  ers_rst_ic i_ic (.core_clk(core_clk), .hold(hold),
    .rst_pin_n(rst_pin_n));

  // Clock, 25 ns period
  initial begin
    forever #12.5 core_clk = ~core_clk;
  end

  // ========================================================
  // Shared tasks
  task automatic chk(input bit ok, input string msg);
    comparisons++;
    if (!ok) begin
      error_cnt++;
      $display("[ERR] %0t %s", $time, msg);
    end
  endtask

  // Sample 1 ns after the edge so its updates have landed
  task automatic tick(input int k);
    repeat (k) @(posedge core_clk);
    #1;
  endtask

  // Bounded wait for start of execution, counting init cycles
  task automatic wait_run(output int ri);
    ri = 0;
    for (int i = 0; i < 400 && fetch_start !== 1'b1; i++) begin
      tick(1);
      if (reg_init === 1'b1) ri++;
    end
    chk(fetch_start === 1'b1 && pc_start === 12'h000, "bad start");
    tick(1);
    chk(fetch_start === 1'b0 && sys_rst === 1'b0, "not running");
  endtask

  task automatic summarize();
    $display("comparisons %0d mismatches %0d", comparisons, error_cnt);
    if (error_cnt == 0 && comparisons > 0) begin
      $display("DONE - PASS");
    end else begin
      $display("DONE - FAIL");
    end
    $finish;
  endtask

  // ========================================================
  // Scenarios
  task automatic t_boot();
    tick(20);
    chk(seq_phase === ST_HOLD && sys_rst === 1'b1, "pin hold");
    @(posedge core_clk) osc_ready <= 1'b0;
    @(posedge core_clk) hold <= 1'b0;
    n = 0;
    repeat (40) begin
      tick(1);
      if (reg_init === 1'b1) n++;
    end
    chk(n == INIT_N, "init length");
    chk(seq_phase === ST_WARM && sys_rst === 1'b1, "no warm wait");
    @(posedge core_clk) osc_ready <= 1'b1;
    wait_run(n);
    $display("test boot done");
  endtask

  task automatic t_pin_run();
    @(posedge core_clk) hold <= 1'b1;
    tick(8);
    chk(seq_phase === ST_HOLD && sys_rst === 1'b1, "pin in run");
    @(posedge core_clk) hold <= 1'b0;
    wait_run(n);
    chk(n == INIT_N, "rerun init");
    $display("test pin_run done");
  endtask

  task automatic t_pin_off();
    @(posedge core_clk) rst_pin_en <= 1'b0;
    tick(4);
    @(posedge core_clk) hold <= 1'b1;
    tick(20);
    chk(seq_phase === ST_RUN && sys_rst === 1'b0, "pin not off");
    @(posedge core_clk) hold <= 1'b0;
    tick(10);
    @(posedge core_clk) rst_pin_en <= 1'b1;
    tick(4);
    $display("test pin_off done");
  endtask

  task automatic t_wdt();
    @(posedge core_clk) wdt_en <= 1'b1;
    // Clearing more often than the overflow period keeps it running
    repeat (12) begin
      tick(10);
      @(posedge core_clk) wdt_clear <= 1'b1;
      @(posedge core_clk) wdt_clear <= 1'b0;
    end
    chk(seq_phase === ST_RUN && wdt_cause === 1'b0, "clear lost");
    for (int i = 0; i < 60 && sys_rst !== 1'b1; i++) tick(1);
    chk(sys_rst === 1'b1 && wdt_cause === 1'b1, "no overflow");
    @(posedge core_clk) supply_ok <= 1'b0;
    tick(40);
    chk(seq_phase === ST_POWER && sys_rst === 1'b1, "low supply");
    @(posedge core_clk) supply_ok <= 1'b1;
    wait_run(n);
    chk(wdt_cause === 1'b1, "cause lost");
    @(posedge core_clk) wdt_en <= 1'b0;
    $display("test wdt done");
  endtask

  // ========================================================
  // Timeout, well above the few hundred cycles needed
  always @(posedge core_clk) begin
    cycles++;
    if (cycles == 20000) begin
      error_cnt++;
      summarize();
    end
  end

  // Main sequence
  initial begin
    repeat (3) @(posedge core_clk);
    rst <= 1'b0;
    t_boot();
    t_pin_run();
    t_pin_off();
    t_wdt();
    summarize();
  end
endmodule

// ---- shared/ers_pkg.sv ----
// ==========================================================
// Reset sequencer constants
package ers_pkg;

  // Sequencer phases, one-hot
  typedef enum logic [4:0] {
    ST_POWER = 5'h01, // Waiting for an adequate supply
    ST_HOLD  = 5'h02, // Waiting for the reset pin release
    ST_INIT  = 5'h04, // Loading register defaults
    ST_WARM  = 5'h08, // Oscillator warm-up
    ST_RUN   = 5'h10  // Program executing
  } ers_state_t;

  // Default sizes and counts
  localparam int PC_W_DEF = 12;
  localparam int CNT_W_DEF = 8;
  localparam int INIT_CYC_DEF = 4;
  localparam int WARM_CYC_DEF = 64;
  localparam int WDT_W_DEF = 8;
  localparam int DIV_W_DEF = 10;
  localparam int WDT_DIV_DEF = 1024;

  // Synchroniser bit positions
  localparam int SYNC_W = 4;
  localparam int SB_PIN = 0;
  localparam int SB_PIN_EN = 1;
  localparam int SB_SUPPLY = 2;
  localparam int SB_OSC = 3;

  // Reset values
  localparam logic [SYNC_W-1:0] SYNC_RST = 4'h0;
  localparam logic RST_ASSERTED = 1'b1;

endpackage

// ---- shared/ers_sync_if.sv ----
`timescale 1ns/1ps
// ==========================================================
// Raw inputs in, clock-domain copies out
interface ers_sync_if #(
  parameter int W = 4
);
  logic [W-1:0] raw;
  logic [W-1:0] sync;
  modport sync_side (input raw, output sync);
  modport user (output raw, input sync);
endinterface
